// *** buf_walker.sv ***
// Buffer address and byte count pair that walks one memory buffer
module buf_walker #(
	parameter int AW = 32,	// Address width
	parameter int CW = 16	// Count width
) (
	input  wire logic          clk,       // System clock
	input  wire logic          addr_load, // Load the buffer address
	input  wire logic [AW-1:0] addr_in,   // Address to load
	input  wire logic          cnt_load,  // Load the byte count
	input  wire logic [CW-1:0] cnt_in,    // Count to load
	input  wire logic          step,      // One byte moved
	output logic      [AW-1:0] addr,      // Current buffer address
	output logic      [CW-1:0] cnt,       // Bytes left in buffer
	output logic               cnt_zero   // Buffer used up
);

	logic [AW-1:0] addr_q;
	logic [CW-1:0] cnt_q;

	// Address walk; no reset so state survives a chip reset
	always_ff @(posedge clk) begin
		if (addr_load) begin
			addr_q <= addr_in;
		end else if (step && !cnt_zero) begin
			addr_q <= addr_q + AW'(1);
		end
	end

	// Count walk, stops at zero
	always_ff @(posedge clk) begin
		if (cnt_load) begin
			cnt_q <= cnt_in;
		end else if (step && !cnt_zero) begin
			cnt_q <= cnt_q - CW'(1);
		end
	end

	assign addr     = addr_q;
	assign cnt      = cnt_q;
	assign cnt_zero = (cnt_q == '0);

endmodule : buf_walker

// *** fbp_check_sva.sv ***
// Port assertions for the frame pointer set
module fbp_check (
	input wire logic       clk,                   // Clock
	input wire logic       rstn,                  // Reset, low
	input wire logic       cmd_valid,             // Command strobe
	input wire logic [7:0] cmd_code,              // Command code
	input wire logic       cmd_busy,              // Busy
	input wire logic       mem_req,               // Memory request
	input wire logic [31:0] mem_addr,             // Byte address
	input wire logic       mem_ack,               // Access done
	input wire logic       transparent_mode,      // Transparent op
	input wire logic       rx_byte_in,            // Byte received
	input wire logic       bts_clear,             // Flag clear
	input wire logic       buffer_too_short_flag, // Overflow flag
	input wire logic       frame_reject_req,      // X.25 overflow
	input wire logic       nrzi_sel,              // Line code
	input wire logic       burst_limit_sel,       // Burst of eight
	input wire logic       byte_order_sel,        // Byte order
	input wire logic       bus_width_sel,         // Bus width
	input wire logic       byte_swap              // Swap
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Command taken by the sequencer
	wire take = cmd_valid && !cmd_busy;

	setup_load_a: assert property (
		take && cmd_code[7:5] == 3'b110 |-> ##2 {nrzi_sel, burst_limit_sel,
		byte_order_sel, bus_width_sel} == $past({cmd_code[4:3],
		cmd_code[1:0]}, 2)) else $error("setup bits not loaded");
	soft_clear_a: assert property (
		take && cmd_code == 8'hff |-> ##2 !nrzi_sel && !burst_limit_sel
		&& !byte_order_sel && !bus_width_sel) else $error("soft reset kept");
	hw_clear_a: assert property (disable iff (1'b0)
		!rstn |=> !nrzi_sel && !bus_width_sel && !buffer_too_short_flag)
		else $error("hard reset kept setup");
	swap_rule_a: assert property (
		byte_swap == (byte_order_sel && bus_width_sel))
		else $error("byte swap wrong");
	bts_hold_a: assert property (
		buffer_too_short_flag && !bts_clear && !take |=> buffer_too_short_flag)
		else $error("flag dropped");
	bts_cause_a: assert property (
		$rose(buffer_too_short_flag) |-> $past(transparent_mode) &&
		($past(rx_byte_in) || $past(rx_byte_in, 2))) else $error("bad flag");
	reject_cause_a: assert property (
		frame_reject_req |-> !$past(transparent_mode) &&
		($past(rx_byte_in) || $past(rx_byte_in, 2))) else $error("bad reject");
	reject_pulse_a: assert property (
		frame_reject_req |=> !frame_reject_req) else $error("reject too long");
	req_hold_a: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("request dropped early");
	cover property (take && cmd_code == 8'h8f);
	cover property ($rose(buffer_too_short_flag));
	cover property (frame_reject_req);
endmodule : fbp_check

bind frame_buffer_pointer_set fbp_check chk (.*);

// *** fbp_mem_model.sv ***
// Shared memory model answering the block's DMA requests
module fbp_mem_model (
	input wire logic        clk,       // Clock
	input wire logic        mem_req,   // Request
	input wire logic        mem_we,    // Write
	input wire logic [31:0] mem_addr,  // Byte address
	input wire logic [15:0] mem_wdata, // Write word
	input wire logic [1:0]  wait_cyc,  // Wait states
	output logic     [15:0] mem_rdata, // Read word
	output logic            mem_ack    // Access done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] m [0:255];  // Word store
	logic [15:0] rd_q;       // Last read word
	logic [1:0]  dly_q = 2'b00;
	// One ack per request after the chosen wait
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		if (mem_req && !mem_ack) begin
			if (dly_q == wait_cyc) begin
				mem_ack <= 1'b1;
				dly_q <= 2'b00;
				if (mem_we)
					m[mem_addr[8:1]] <= mem_wdata;
				else
					rd_q <= m[mem_addr[8:1]];
			end else
				dly_q <= dly_q + 2'b01;
		end
	end
	// Read bus shows junk outside the ack cycle
	assign mem_rdata = mem_ack ? rd_q : ~rd_q;
endmodule : fbp_mem_model

// *** fbp_pkg.sv ***
// Constants, command codes and table layouts for the frame pointer set
package fbp_pkg;

	// ------------------------------------------------------------------
	// Host command codes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_LOAD_ADDR   = 8'h84;
	localparam logic [7:0] CMD_LOAD_TX     = 8'h85;
	localparam logic [7:0] CMD_LOAD_RX     = 8'h86;
	localparam logic [7:0] CMD_LOAD_PARAMS = 8'h87;
	localparam logic [7:0] CMD_DUMP_PARAMS = 8'h8c;
	localparam logic [7:0] CMD_DUMP_REGS   = 8'h8f;
	localparam logic [7:0] CMD_SOFT_RESET  = 8'hff;
	localparam logic [7:0] CMD_HWCFG_MASK  = 8'he0;
	localparam logic [7:0] CMD_HWCFG_CODE  = 8'hc0;

	// ------------------------------------------------------------------
	// Hardware setup register layout
	// ------------------------------------------------------------------
	localparam logic [7:0] HC_VALID_BITS = 8'h1b;
	localparam logic [7:0] HC_RESET      = 8'h00;
	localparam int         HC_NRZI_BIT   = 4;
	localparam int         HC_BURST_BIT  = 3;
	localparam int         HC_ORDER_BIT  = 1;
	localparam int         HC_WIDTH_BIT  = 0;
	localparam int         BURST_LIMIT_CYCLES = 8;

	// ------------------------------------------------------------------
	// Station table word indices (16-bit words)
	// ------------------------------------------------------------------
	localparam logic [4:0] ST_LOCAL      = 5'h08;
	localparam logic [4:0] ST_REMOTE     = 5'h09;
	localparam logic [4:0] ST_RX_TABLE_FUNC_CODE       = 5'h0a;
	localparam logic [4:0] ST_TX_TABLE_FUNC_CODE       = 5'h0d;
	localparam logic [4:0] ST_NEXT_RX_HI = 5'h16;

	// ------------------------------------------------------------------
	// Frame descriptor layout and dump area
	// ------------------------------------------------------------------
	localparam logic [4:0]  DESC_FC       = 5'h00;
	localparam logic [4:0]  DESC_FINAL    = 5'h04;
	localparam logic [31:0] DESC_BYTES    = 32'h0000_000a;
	localparam int          DESC_LAST_BIT = 15;
	localparam logic [4:0]  K_DESC_FIRST  = 5'h03;
	localparam logic [4:0]  K_ADDR_HI     = 5'h04;
	localparam logic [4:0]  K_ADDR_LO     = 5'h05;
	localparam logic [4:0]  K_LEN         = 5'h06;
	localparam logic [4:0]  K_PARAM_LAST  = 5'h03;
	localparam logic [4:0]  K_DUMP_LAST   = 5'h10;
	localparam logic [3:0]  FC_RESET      = 4'h0;
	localparam logic [31:0] PTR_RESET     = 32'h0000_0000;
	localparam logic [7:0]  ADDR_RESET    = 8'h00;

	// ------------------------------------------------------------------
	// Sequencer types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_LOAD_ADDR   = 3'b000,
		OP_LOAD_TX     = 3'b001,
		OP_LOAD_RX     = 3'b010,
		OP_RX_FINISH   = 3'b011,
		OP_DUMP_PARAMS = 3'b100,
		OP_DUMP_REGS   = 3'b101
	} op_t;

	typedef enum logic [1:0] {
		SQ_IDLE  = 2'b00,
		SQ_ISSUE = 2'b01,
		SQ_WAIT  = 2'b10
	} seq_state_t;

	typedef enum logic [1:0] {
		BASE_ST   = 2'b00,
		BASE_TX   = 2'b01,
		BASE_RX   = 2'b10,
		BASE_DUMP = 2'b11
	} base_t;

endpackage : fbp_pkg

// *** frame_buffer_pointer_set.sv ***
// Pointer, count, function code, address and setup registers of the link
module frame_buffer_pointer_set (
	input  wire logic        clk,                   // 250 MHz clock
	input  wire logic        rstn,                  // Sync reset, low
	input  wire logic        cmd_valid,             // Command strobe
	input  wire logic [7:0]  cmd_code,              // Command code
	output logic             cmd_busy,              // Sequencer busy
	output logic             cmd_done,              // Command finished
	input  wire logic [31:0] station_base,          // Station table base
	input  wire logic [31:0] dump_base,             // Dump area base
	output logic             mem_req,               // Memory request
	output logic             mem_we,                // Memory write
	output logic [31:0]      mem_addr,              // Byte address
	output logic [15:0]      mem_wdata,             // Write word
	input  wire logic [15:0] mem_rdata,             // Read word
	input  wire logic        mem_ack,               // Access done
	input  wire logic        transparent_mode,      // Transparent op
	input  wire logic        tx_byte_sent,          // Byte sent
	input  wire logic        tx_next_buf,           // Move to next buf
	output logic             tx_buf_ready,          // Tx bytes remain
	input  wire logic        rx_byte_in,            // Byte received
	input  wire logic        rx_frame_end,          // Frame complete
	output logic             rx_buf_ready,          // Rx room remains
	input  wire logic        bts_clear,             // Clear too short
	output logic             buffer_too_short_flag, // Sticky overflow
	output logic             frame_reject_req,      // X.25 overflow
	output logic             nrzi_sel,              // NRZI line code
	output logic             burst_limit_sel,       // Burst of eight
	output logic             byte_order_sel,        // Byte order bit
	output logic             bus_width_sel,         // 16-bit bus
	output logic             byte_swap              // Swap on 16 bit
);
	import fbp_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	seq_state_t  state_q;
	op_t         op_q;
	logic [4:0]  k_q;
	logic        from_cmd_q;
	logic        busy_q;
	logic        done_q;
	logic        req_q;
	logic        we_q;
	logic [31:0] addr_q;
	logic [15:0] wdata_q;
	logic [3:0]  tx_table_func_code_q;
	logic [31:0] tx_table_address_q;
	logic [3:0]  rx_table_func_code_q;
	logic [31:0] rx_table_address_q;
	logic [3:0]  tx_buffer_func_code_q;
	logic [3:0]  rx_buffer_func_code_q;
	logic [7:0]  local_station_address_q;
	logic [7:0]  remote_station_address_q;
	logic [7:0]  hardware_setup_q;
	logic        swap_q;
	logic [15:0] hi_hold_q;
	logic        tx_last_q;
	logic        rx_last_q;
	logic        tx_loaded_q;
	logic        rx_loaded_q;
	logic        tx_ready_q;
	logic        rx_ready_q;
	logic        tx_pend_q;
	logic        rx_pend_q;
	logic        bts_q;
	logic        frmr_q;
	base_t       s_base;
	logic [4:0]  s_word;
	logic        s_we;
	logic [15:0] s_wdata;
	logic        s_last;
	logic [31:0] base_addr;
	logic        idle;
	logic        is_hwcfg;
	logic        soft_rst;
	logic        clr;
	logic        rd_take;
	logic        wr_end;
	logic        start_rx;
	logic        start_tx;
	logic [31:0] tx_buffer_address;
	logic [15:0] tx_buffer_count;
	logic        tx_zero;
	logic [31:0] rx_buffer_address;
	logic [15:0] rx_buffer_count;
	logic        rx_zero;
	logic        tx_step;
	logic        rx_step;
	logic        rx_over;

	// ------------------------------------------------------------------
	// Command decode and sequencer triggers
	// ------------------------------------------------------------------
	assign idle     = (state_q == SQ_IDLE);
	assign is_hwcfg = ((cmd_code & CMD_HWCFG_MASK) == CMD_HWCFG_CODE);
	assign soft_rst = idle && cmd_valid && (cmd_code == CMD_SOFT_RESET);
	assign clr      = !rstn || soft_rst;
	assign start_rx = idle && !cmd_valid && rx_pend_q;
	assign start_tx = idle && !cmd_valid && !rx_pend_q && tx_pend_q;
	assign rd_take  = (state_q == SQ_WAIT) && mem_ack && !we_q;
	assign wr_end   = (state_q == SQ_WAIT) && mem_ack && s_last;

	// ------------------------------------------------------------------
	// Step decode: which word each step touches
	// ------------------------------------------------------------------
	always_comb begin
		s_base  = BASE_ST;
		s_word  = 5'h00;
		s_we    = 1'b0;
		s_wdata = 16'h0000;
		s_last  = 1'b0;
		case (op_q)
			OP_LOAD_ADDR: begin
				s_word = (k_q == 5'h00) ? ST_LOCAL : ST_REMOTE;
				s_last = (k_q != 5'h00);
			end
			OP_LOAD_TX, OP_LOAD_RX: begin
				if (k_q < K_DESC_FIRST) begin
					s_word = ((op_q == OP_LOAD_TX) ? ST_TX_TABLE_FUNC_CODE : ST_RX_TABLE_FUNC_CODE) + k_q;
				end else begin
					s_base = (op_q == OP_LOAD_TX) ? BASE_TX : BASE_RX;
					s_word = DESC_FC + (k_q - K_DESC_FIRST);
				end
				s_last = (k_q == K_LEN);
			end
			OP_RX_FINISH: begin
				s_base  = BASE_RX;
				s_word  = DESC_FINAL;
				s_we    = 1'b1;
				s_wdata = rx_buffer_count;
				s_last  = 1'b1;
			end
			OP_DUMP_PARAMS: begin
				s_word = ST_NEXT_RX_HI + k_q;
				s_we   = 1'b1;
				s_last = (k_q == K_PARAM_LAST);
				case (k_q[1:0])
					2'h0:    s_wdata = rx_table_address_q[31:16];
					2'h1:    s_wdata = rx_table_address_q[15:0];
					2'h2:    s_wdata = tx_table_address_q[31:16];
					default: s_wdata = tx_table_address_q[15:0];
				endcase
			end
			OP_DUMP_REGS: begin
				s_base = BASE_DUMP;
				s_word = k_q;
				s_we   = 1'b1;
				s_last = (k_q == K_DUMP_LAST);
				case (k_q)
					5'h00:   s_wdata = {12'h000, tx_table_func_code_q};
					5'h01:   s_wdata = tx_table_address_q[31:16];
					5'h02:   s_wdata = tx_table_address_q[15:0];
					5'h03:   s_wdata = tx_buffer_address[31:16];
					5'h04:   s_wdata = tx_buffer_address[15:0];
					5'h05:   s_wdata = {12'h000, tx_buffer_func_code_q};
					5'h06:   s_wdata = tx_buffer_count;
					5'h07:   s_wdata = rx_table_address_q[31:16];
					5'h08:   s_wdata = rx_table_address_q[15:0];
					5'h09:   s_wdata = {12'h000, rx_table_func_code_q};
					5'h0a:   s_wdata = rx_buffer_address[31:16];
					5'h0b:   s_wdata = rx_buffer_address[15:0];
					5'h0c:   s_wdata = {12'h000, rx_buffer_func_code_q};
					5'h0d:   s_wdata = rx_buffer_count;
					5'h0e:   s_wdata = {8'h00, local_station_address_q};
					5'h0f:   s_wdata = {8'h00, remote_station_address_q};
					default: s_wdata = {8'h00, hardware_setup_q};
				endcase
			end
			default: s_last = 1'b1;
		endcase
	end

	// Base address of the region the step lands in
	always_comb begin
		case (s_base)
			BASE_TX:   base_addr = tx_table_address_q;
			BASE_RX:   base_addr = rx_table_address_q;
			BASE_DUMP: base_addr = dump_base;
			default:   base_addr = station_base;
		endcase
	end

	// ------------------------------------------------------------------
	// Sequencer: one memory word per step, request held until ack
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q    <= SQ_IDLE;
			op_q       <= OP_LOAD_ADDR;
			k_q        <= 5'h00;
			from_cmd_q <= 1'b0;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
			req_q      <= 1'b0;
			we_q       <= 1'b0;
			addr_q     <= PTR_RESET;
			wdata_q    <= 16'h0000;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				SQ_IDLE: begin
					if (cmd_valid) begin
						k_q        <= 5'h00;
						from_cmd_q <= 1'b1;
						state_q    <= SQ_ISSUE;
						busy_q     <= 1'b1;
						case (cmd_code)
							CMD_LOAD_ADDR, CMD_LOAD_PARAMS: op_q <= OP_LOAD_ADDR;
							CMD_LOAD_TX:     op_q <= OP_LOAD_TX;
							CMD_LOAD_RX:     op_q <= OP_LOAD_RX;
							CMD_DUMP_PARAMS: op_q <= OP_DUMP_PARAMS;
							CMD_DUMP_REGS:   op_q <= OP_DUMP_REGS;
							default: begin
								state_q <= SQ_IDLE;
								busy_q  <= 1'b0;
								done_q  <= soft_rst || is_hwcfg;
							end
						endcase
					end else if (start_rx && rx_loaded_q) begin
						op_q       <= OP_RX_FINISH;
						k_q        <= 5'h00;
						from_cmd_q <= 1'b0;
						state_q    <= SQ_ISSUE;
						busy_q     <= 1'b1;
					end else if (start_tx && tx_loaded_q && !tx_last_q) begin
						op_q       <= OP_LOAD_TX;
						k_q        <= K_DESC_FIRST;
						from_cmd_q <= 1'b0;
						state_q    <= SQ_ISSUE;
						busy_q     <= 1'b1;
					end
				end
				SQ_ISSUE: begin
					req_q   <= 1'b1;
					we_q    <= s_we;
					wdata_q <= s_wdata;
					addr_q  <= base_addr + {26'h0, s_word, 1'b0};
					state_q <= SQ_WAIT;
				end
				SQ_WAIT: begin
					if (mem_ack) begin
						req_q <= 1'b0;
						if (!s_last) begin
							k_q     <= k_q + 5'h01;
							state_q <= SQ_ISSUE;
						end else if (op_q == OP_RX_FINISH && !rx_last_q) begin
							op_q    <= OP_LOAD_RX;
							k_q     <= K_DESC_FIRST;
							state_q <= SQ_ISSUE;
						end else begin
							state_q <= SQ_IDLE;
							busy_q  <= 1'b0;
							done_q  <= from_cmd_q;
						end
					end
				end
				default: state_q <= SQ_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Table pointers, table codes and station addresses (cleared)
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (clr) begin
			tx_table_func_code_q     <= FC_RESET;
			tx_table_address_q       <= PTR_RESET;
			rx_table_func_code_q     <= FC_RESET;
			rx_table_address_q       <= PTR_RESET;
			local_station_address_q  <= ADDR_RESET;
			remote_station_address_q <= ADDR_RESET;
		end else begin
			if (rd_take && op_q == OP_LOAD_ADDR) begin
				if (k_q == 5'h00) begin
					local_station_address_q <= mem_rdata[7:0];
				end else begin
					remote_station_address_q <= mem_rdata[7:0];
				end
			end
			if (rd_take && op_q == OP_LOAD_TX) begin
				if (k_q == 5'h00) begin
					tx_table_func_code_q <= mem_rdata[3:0];
				end else if (k_q == 5'h02) begin
					tx_table_address_q <= {hi_hold_q, mem_rdata};
				end
			end
			if (rd_take && op_q == OP_LOAD_RX) begin
				if (k_q == 5'h00) begin
					rx_table_func_code_q <= mem_rdata[3:0];
				end else if (k_q == 5'h02) begin
					rx_table_address_q <= {hi_hold_q, mem_rdata};
				end
			end
			// Advance past the used descriptor, also past the last one
			if (wr_end && op_q == OP_RX_FINISH) begin
				rx_table_address_q <= rx_table_address_q + DESC_BYTES;
			end
			if (start_tx && tx_loaded_q) begin
				tx_table_address_q <= tx_table_address_q + DESC_BYTES;
			end
		end
	end

	// ------------------------------------------------------------------
	// Descriptor capture: buffer codes survive reset
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rd_take) begin
			hi_hold_q <= mem_rdata;
		end
		if (rd_take && k_q == K_DESC_FIRST && op_q == OP_LOAD_TX) begin
			tx_buffer_func_code_q <= mem_rdata[3:0];
			tx_last_q             <= mem_rdata[DESC_LAST_BIT];
		end
		if (rd_take && k_q == K_DESC_FIRST && op_q == OP_LOAD_RX) begin
			rx_buffer_func_code_q <= mem_rdata[3:0];
			rx_last_q             <= mem_rdata[DESC_LAST_BIT];
		end
	end

	// Walkers for the current transmit and receive buffers
	assign tx_step = tx_byte_sent && tx_loaded_q && !tx_zero;
	assign rx_step = rx_byte_in && rx_loaded_q && !rx_zero;
	assign rx_over = rx_byte_in && !(rx_loaded_q && !rx_zero);

	buf_walker #(.AW(32), .CW(16)) u_tx_walk (
		.clk       (clk),
		.addr_load (rd_take && op_q == OP_LOAD_TX && k_q == K_ADDR_LO),
		.addr_in   ({hi_hold_q, mem_rdata}),
		.cnt_load  (rd_take && op_q == OP_LOAD_TX && k_q == K_LEN),
		.cnt_in    (mem_rdata),
		.step      (tx_step),
		.addr      (tx_buffer_address),
		.cnt       (tx_buffer_count),
		.cnt_zero  (tx_zero)
	);

	buf_walker #(.AW(32), .CW(16)) u_rx_walk (
		.clk       (clk),
		.addr_load (rd_take && op_q == OP_LOAD_RX && k_q == K_ADDR_LO),
		.addr_in   ({hi_hold_q, mem_rdata}),
		.cnt_load  (rd_take && op_q == OP_LOAD_RX && k_q == K_LEN),
		.cnt_in    (mem_rdata),
		.step      (rx_step),
		.addr      (rx_buffer_address),
		.cnt       (rx_buffer_count),
		.cnt_zero  (rx_zero)
	);

	// ------------------------------------------------------------------
	// Buffer state, pending reloads and overflow reporting
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (clr) begin
			tx_loaded_q <= 1'b0;
			rx_loaded_q <= 1'b0;
			tx_ready_q  <= 1'b0;
			rx_ready_q  <= 1'b0;
			tx_pend_q   <= 1'b0;
			rx_pend_q   <= 1'b0;
			bts_q       <= 1'b0;
			frmr_q      <= 1'b0;
		end else begin
			if (rd_take && k_q == K_LEN && op_q == OP_LOAD_TX) begin
				tx_loaded_q <= 1'b1;
			end else if (start_tx && tx_last_q) begin
				tx_loaded_q <= 1'b0;
			end
			if (rd_take && k_q == K_LEN && op_q == OP_LOAD_RX) begin
				rx_loaded_q <= 1'b1;
			end else if (wr_end && op_q == OP_RX_FINISH && rx_last_q) begin
				rx_loaded_q <= 1'b0;
			end
			tx_ready_q <= tx_loaded_q && !tx_zero && !busy_q;
			rx_ready_q <= rx_loaded_q && !rx_zero && !busy_q;
			// A new event beats the start that consumes the old one
			tx_pend_q <= tx_next_buf || (tx_pend_q && !start_tx);
			rx_pend_q <= rx_frame_end || (rx_pend_q && !start_rx);
			// Overflow flag: set wins over clear
			bts_q <= (rx_over && transparent_mode) || (bts_q && !bts_clear);
			frmr_q <= rx_over && !transparent_mode;
		end
	end

	// ------------------------------------------------------------------
	// Hardware setup register and its decoded controls
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (clr) begin
			hardware_setup_q <= HC_RESET;
			swap_q           <= 1'b0;
		end else if (idle && cmd_valid && is_hwcfg) begin
			hardware_setup_q <= cmd_code & HC_VALID_BITS;
			swap_q           <= cmd_code[HC_ORDER_BIT] &&
			                    cmd_code[HC_WIDTH_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign cmd_busy              = busy_q;
	assign cmd_done              = done_q;
	assign mem_req               = req_q;
	assign mem_we                = we_q;
	assign mem_addr              = addr_q;
	assign mem_wdata             = wdata_q;
	assign tx_buf_ready          = tx_ready_q;
	assign rx_buf_ready          = rx_ready_q;
	assign buffer_too_short_flag = bts_q;
	assign frame_reject_req      = frmr_q;
	assign nrzi_sel              = hardware_setup_q[HC_NRZI_BIT];
	assign burst_limit_sel       = hardware_setup_q[HC_BURST_BIT];
	assign byte_order_sel        = hardware_setup_q[HC_ORDER_BIT];
	assign bus_width_sel         = hardware_setup_q[HC_WIDTH_BIT];
	assign byte_swap             = swap_q;

endmodule : frame_buffer_pointer_set

// *** testbench.sv ***
// Self-checking bench for the frame pointer set
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import fbp_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, transparent_mode = 1'b1;
	logic [7:0] cmd_code = 8'h00, hc;
	logic cmd_busy, cmd_done, mem_req, mem_we, mem_ack, buffer_too_short_flag;
	logic [31:0] mem_addr, station_base = 32'h0, dump_base = 32'h100;
	logic [15:0] mem_wdata, mem_rdata;
	logic tx_byte_sent = 0, tx_next_buf = 0, rx_byte_in = 0, rx_frame_end = 0;
	logic bts_clear = 0, frame_reject_req, rej_seen = 0, byte_swap;
	logic nrzi_sel, burst_limit_sel, byte_order_sel, bus_width_sel;
	logic tx_buf_ready, rx_buf_ready;
	logic [1:0] wait_cyc = 2'b00;
	int error_cnt = 0, tests_run = 0, seed = 32'h454d;
	logic [47:0] exp_q [$];
	logic [15:0] cleared [17] = '{0, 0, 0, 0, 16'h3002, 2, 2, 0, 0, 0, 0,
		16'h2003, 6, 0, 0, 0, 0};
	localparam logic [23:0] PRE [15] = '{24'h085a3c, 24'h09a5c3, 24'h0a0003,
		24'h0c0080, 24'h0d0007, 24'h0f00c0, 24'h400005, 24'h421000, 24'h430002,
		24'h458006, 24'h472000, 24'h480003, 24'h608002, 24'h623000, 24'h630004};

	frame_buffer_pointer_set uut (.*);
	fbp_mem_model mem (.*);
	always #2 clk = ~clk;

	task automatic chk(input logic [47:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Wait for three quiet cycles in a row so pending reloads run first
	task automatic settle;
		int quiet = 0;
		for (int n = 0; quiet < 3 && n < 300; n++) begin
			@(posedge clk) #1;
			quiet = (cmd_busy === 1'b0) ? quiet + 1 : 0;
		end
	endtask : settle
	task automatic cmd(input logic [7:0] c);
		int n;
		settle();
		cmd_code = c;
		cmd_valid = 1'b1;
		wait_cyc = $random(seed);
		@(posedge clk) #1;
		cmd_valid = 1'b0;
		for (n = 0; cmd_done !== 1'b1 && n < 300; n++) @(posedge clk) #1;
		if (n == 300) begin
			error_cnt++;
			$display("Error %0t: command %h hung", $time, c);
		end
	endtask : cmd
	task automatic pulse(input int which, cnt);
		repeat (cnt) begin
			{tx_byte_sent, tx_next_buf, rx_byte_in, rx_frame_end, bts_clear}
				= 5'b10000 >> which;
			@(posedge clk) #1;
			{tx_byte_sent, tx_next_buf, rx_byte_in, rx_frame_end, bts_clear} = 0;
			@(posedge clk) #1;
		end
	endtask : pulse
	task automatic ew(input logic [31:0] a, input logic [15:0] d);
		exp_q.push_back({a, d});
	endtask : ew
	task automatic dump(input logic [15:0] v [17]);
		foreach (v[i]) ew(32'h100 + 2 * i, v[i]);
		cmd(CMD_DUMP_REGS);
		$display("register dump done at %0t", $time);
	endtask : dump
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	// Memory writes checked against the oldest note
	always @(posedge clk) begin
		if (frame_reject_req)
			rej_seen <= 1'b1;
		if (mem_req && mem_we && mem_ack)
			chk({mem_addr, mem_wdata}, exp_q.pop_front());
	end

	initial begin
		foreach (mem.m[i]) mem.m[i] = 16'h0;
		foreach (PRE[i]) mem.m[PRE[i][23:16]] = PRE[i][15:0];
		repeat (3) @(posedge clk) #1;
		rstn = 1'b1;
		chk({nrzi_sel, bus_width_sel, buffer_too_short_flag}, 0);
		for (int i = 0; i < 6; i++) begin
			hc = 8'hc0 | ($random(seed) & 8'h1f);
			cmd(hc);
			chk({nrzi_sel, burst_limit_sel, byte_order_sel, bus_width_sel},
				{hc[4:3], hc[1:0]});
			chk(byte_swap, hc[1] & hc[0]);
		end
		cmd(CMD_LOAD_ADDR);
		cmd(CMD_LOAD_RX);
		cmd(CMD_LOAD_TX);
		@(posedge clk) #1;
		chk({tx_buf_ready, rx_buf_ready}, 2'b11);
		pulse(2, 3);
		chk({buffer_too_short_flag, rej_seen}, 2'b10);
		chk({tx_buf_ready, rx_buf_ready}, 2'b10);
		ew(32'h88, 0);
		pulse(3, 1);
		settle();
		transparent_mode = 1'b0;
		pulse(2, 4);
		settle();
		chk(rej_seen, 1);
		pulse(4, 1);
		chk(buffer_too_short_flag, 0);
		pulse(0, 2);
		ew(32'h2c, 0); ew(32'h2e, 16'h8a); ew(32'h30, 0); ew(32'h32, 16'hc0);
		cmd(CMD_DUMP_PARAMS);
		dump('{7, 0, 16'hc0, 0, 16'h3002, 2, 2, 0, 16'h8a, 3, 0, 16'h2003,
			6, 0, 16'h3c, 16'hc3, 16'(hc & 8'h1b)});
		ew(32'h92, 0);
		pulse(3, 1);
		pulse(1, 1);
		ew(32'h2c, 0); ew(32'h2e, 16'h94); ew(32'h30, 0); ew(32'h32, 16'hca);
		cmd(CMD_DUMP_PARAMS);
		cmd(CMD_SOFT_RESET);
		dump(cleared);
		rstn = 1'b0;
		repeat (2) @(posedge clk) #1;
		rstn = 1'b1;
		dump(cleared);
		chk(exp_q.size(), 0);
		wrap_up();
	end

	// Cut a hang short
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule : testbench
